// *** hw/cpu_system_register_file.sv ***
`timescale 1ns/1ps
module cpu_system_register_file (
  input  wire logic        ref_clk,       // 40 MHz clock
  input  wire logic        reset_n,       // Async reset, active low
  input  wire logic        load_sr,       // Load-to-system-register instruction
  input  wire logic        read_sr,       // Read-system-register instruction
  input  wire logic [4:0]  sr_number,     // System register number
  input  wire logic [31:0] sr_wdata,      // Data to load
  input  wire logic [2:0]  save_event,    // Saving event kind
  input  wire logic [31:0] next_pc,       // Address of following instruction
  input  wire logic [31:0] cause_in,      // Interrupt cause value
  input  wire logic        cause_we,      // Cause update strobe
  input  wire logic        status_we,     // Pipeline status update strobe
  input  wire logic [31:0] status_in,     // Pipeline status value
  input  wire logic        pc_inc,        // Step pc by one halfword
  input  wire logic        pc_load,       // Branch or vector load
  input  wire logic [31:0] pc_target,     // Branch target
  input  wire logic        debug_return,  // Debug-return instruction
  output logic      [31:0] sr_rdata_r,    // Read data
  output logic             sr_rvalid_r,   // Read data valid pulse
  output logic             sr_rerror_r,   // Read not permitted pulse
  output logic      [31:0] pc_r,          // Program counter
  output logic      [31:0] status_r,      // Program status word
  output logic      [31:0] tc_base_r,     // Table-call base pointer
  output logic             debug_mode_r   // Inside debug trap handler
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_meta_r;
  logic rst_n_r;

  // Only the second flop drives the internal reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event decode
  sysreg_pkg::save_event_t ev;
  logic ev_int;
  logic ev_nmi;
  logic ev_dbg;
  logic ev_tc;
  logic ev_debug_trap_exception;

  always_comb begin
    ev        = sysreg_pkg::save_event_t'(save_event);
    ev_int    = 1'b0;
    ev_nmi    = 1'b0;
    ev_dbg    = 1'b0;
    ev_tc     = 1'b0;
    ev_debug_trap_exception = 1'b0;
    case (ev)
      sysreg_pkg::EV_SW_EXCEPTION,
      sysreg_pkg::EV_MASKABLE_INT: begin
        ev_int = 1'b1;
      end
      sysreg_pkg::EV_NMI: begin
        ev_nmi = 1'b1;
      end
      sysreg_pkg::EV_EXC_TRAP,
      sysreg_pkg::EV_DEBUG_BREAK_STEP: begin
        ev_dbg = 1'b1;
      end
      sysreg_pkg::EV_DEBUG_TRAP: begin
        ev_dbg    = 1'b1;
        ev_debug_trap_exception = 1'b1;
      end
      sysreg_pkg::EV_TABLE_CALL: begin
        ev_tc = 1'b1;
      end
      default: begin
        ev_int = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Load decode
  logic ld_int_pc;
  logic ld_nmi_pc;
  logic ld_tc_pc;
  logic ld_dbg_pc;
  logic ld_int_st;
  logic ld_nmi_st;
  logic ld_tc_st;
  logic ld_dbg_st;
  logic ld_status;
  logic ld_tc_base;

  assign ld_int_pc = load_sr && (sr_number == sysreg_pkg::SR_INT_RETURN_PC);
  assign ld_nmi_pc = load_sr && (sr_number == sysreg_pkg::SR_NMI_RETURN_PC);
  assign ld_tc_pc  = load_sr && (sr_number == sysreg_pkg::SR_TC_RETURN_PC);
  assign ld_dbg_pc = load_sr && (sr_number == sysreg_pkg::SR_DEBUG_RETURN_PC);
  // Cause number has no load strobe at all
  assign ld_int_st  = load_sr && (sr_number == sysreg_pkg::SR_INT_SAVED_STATUS);
  assign ld_nmi_st  = load_sr && (sr_number == sysreg_pkg::SR_NMI_SAVED_STATUS);
  assign ld_tc_st   = load_sr && (sr_number == sysreg_pkg::SR_TC_SAVED_STATUS);
  assign ld_dbg_st  = load_sr && (sr_number == sysreg_pkg::SR_DEBUG_SAVED_STATUS);
  assign ld_status  = load_sr && (sr_number == sysreg_pkg::SR_PROGRAM_STATUS);
  assign ld_tc_base = load_sr && (sr_number == sysreg_pkg::SR_TABLE_CALL_BASE);

  ////////////////////////////////////////////////////////////////////////////
  // Return pc registers
  logic [31:0] int_return_pc;
  logic [31:0] nmi_return_pc;
  logic [31:0] table_call_return_pc;
  logic [31:0] debug_return_pc;

  pc_save_reg u_int_pc (
    .clk      (ref_clk),
    .rst_n    (rst_n_r),
    .save_en  (ev_int),
    .save_val (next_pc),
    .load_en  (ld_int_pc),
    .load_val (sr_wdata),
    .value_r  (int_return_pc)
  );

  pc_save_reg u_nmi_pc (
    .clk      (ref_clk),
    .rst_n    (rst_n_r),
    .save_en  (ev_nmi),
    .save_val (next_pc),
    .load_en  (ld_nmi_pc),
    .load_val (sr_wdata),
    .value_r  (nmi_return_pc)
  );

  pc_save_reg u_tc_pc (
    .clk      (ref_clk),
    .rst_n    (rst_n_r),
    .save_en  (ev_tc),
    .save_val (next_pc),
    .load_en  (ld_tc_pc),
    .load_val (sr_wdata),
    .value_r  (table_call_return_pc)
  );

  pc_save_reg u_dbg_pc (
    .clk      (ref_clk),
    .rst_n    (rst_n_r),
    .save_en  (ev_dbg),
    .save_val (next_pc),
    .load_en  (ld_dbg_pc),
    .load_val (sr_wdata),
    .value_r  (debug_return_pc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Saved status registers
  logic [31:0] int_saved_status_r;
  logic [31:0] nmi_saved_status_r;
  logic [31:0] table_call_saved_status_r;
  logic [31:0] debug_saved_status_r;

  // Event capture takes priority over a software load
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      int_saved_status_r <= sysreg_pkg::SAVED_ST_RESET;
    end else if (ev_int) begin
      int_saved_status_r <= status_r;
    end else if (ld_int_st) begin
      int_saved_status_r <= sr_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      nmi_saved_status_r <= sysreg_pkg::SAVED_ST_RESET;
    end else if (ev_nmi) begin
      nmi_saved_status_r <= status_r;
    end else if (ld_nmi_st) begin
      nmi_saved_status_r <= sr_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      table_call_saved_status_r <= sysreg_pkg::SAVED_ST_RESET;
    end else if (ev_tc) begin
      table_call_saved_status_r <= status_r;
    end else if (ld_tc_st) begin
      table_call_saved_status_r <= sr_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      debug_saved_status_r <= sysreg_pkg::SAVED_ST_RESET;
    end else if (ev_dbg) begin
      debug_saved_status_r <= status_r;
    end else if (ld_dbg_st) begin
      debug_saved_status_r <= sr_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word, cause, table-call base
  logic [31:0] cause_r;

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      status_r <= sysreg_pkg::STATUS_RESET;
    end else if (ld_status) begin
      status_r <= sr_wdata;
    end else if (status_we) begin
      status_r <= status_in;
    end
  end

  // Cause is never loaded by instruction
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cause_r <= sysreg_pkg::CAUSE_RESET;
    end else if (cause_we) begin
      cause_r <= cause_in;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tc_base_r <= sysreg_pkg::TCB_RESET;
    end else if (ld_tc_base) begin
      tc_base_r <= sr_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Debug trap window
  // A trap in the cycle of a return keeps the window open
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      debug_mode_r <= 1'b0;
    end else if (ev_debug_trap_exception) begin
      debug_mode_r <= 1'b1;
    end else if (debug_return) begin
      debug_mode_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter, not reachable by number
  logic [31:0] pc_sum;
  logic [31:0] pc_nxt;

  // Mask drops any carry out of bit 25
  assign pc_sum = pc_r + sysreg_pkg::PC_STEP;

  always_comb begin
    pc_nxt = pc_r;
    if (pc_load) begin
      pc_nxt = pc_target & sysreg_pkg::PC_MASK;
    end else if (pc_inc) begin
      pc_nxt = pc_sum & sysreg_pkg::PC_MASK;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pc_r <= sysreg_pkg::PC_RESET;
    end else begin
      pc_r <= pc_nxt & sysreg_pkg::PC_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  logic [31:0] rd_val;
  logic        rd_err;

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    case (sr_number)
      sysreg_pkg::SR_INT_RETURN_PC:      rd_val = int_return_pc;
      sysreg_pkg::SR_INT_SAVED_STATUS:   rd_val = int_saved_status_r;
      sysreg_pkg::SR_NMI_RETURN_PC:      rd_val = nmi_return_pc;
      sysreg_pkg::SR_NMI_SAVED_STATUS:   rd_val = nmi_saved_status_r;
      sysreg_pkg::SR_INTERRUPT_CAUSE:    rd_val = cause_r;
      sysreg_pkg::SR_PROGRAM_STATUS:     rd_val = status_r;
      sysreg_pkg::SR_TC_RETURN_PC:       rd_val = table_call_return_pc;
      sysreg_pkg::SR_TC_SAVED_STATUS:    rd_val = table_call_saved_status_r;
      sysreg_pkg::SR_DEBUG_RETURN_PC: begin
        rd_val = debug_mode_r ? debug_return_pc : 32'h0000_0000;
        rd_err = !debug_mode_r;
      end
      sysreg_pkg::SR_DEBUG_SAVED_STATUS: begin
        rd_val = debug_mode_r ? debug_saved_status_r : 32'h0000_0000;
        rd_err = !debug_mode_r;
      end
      sysreg_pkg::SR_TABLE_CALL_BASE:    rd_val = tc_base_r;
      default: begin
        rd_val = 32'h0000_0000;
        rd_err = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sr_rvalid_r <= 1'b0;
      sr_rerror_r <= 1'b0;
    end else begin
      sr_rvalid_r <= read_sr;
      sr_rerror_r <= read_sr && rd_err;
    end
  end

  // Read data holds until the next read
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sr_rdata_r <= 32'h0000_0000;
    end else if (read_sr) begin
      sr_rdata_r <= rd_val;
    end
  end

endmodule

// *** hw/sysreg_pkg.sv ***
package sysreg_pkg;

  // System register numbers
  localparam logic [4:0] SR_INT_RETURN_PC      = 5'h00;
  localparam logic [4:0] SR_INT_SAVED_STATUS   = 5'h01;
  localparam logic [4:0] SR_NMI_RETURN_PC      = 5'h02;
  localparam logic [4:0] SR_NMI_SAVED_STATUS   = 5'h03;
  localparam logic [4:0] SR_INTERRUPT_CAUSE    = 5'h04;
  localparam logic [4:0] SR_PROGRAM_STATUS     = 5'h05;
  localparam logic [4:0] SR_TC_RETURN_PC       = 5'h10;
  localparam logic [4:0] SR_TC_SAVED_STATUS    = 5'h11;
  localparam logic [4:0] SR_DEBUG_RETURN_PC    = 5'h12;
  localparam logic [4:0] SR_DEBUG_SAVED_STATUS = 5'h13;
  localparam logic [4:0] SR_TABLE_CALL_BASE    = 5'h14;

  // Program counter layout
  localparam int          PC_BITS         = 26;
  localparam logic [31:0] PC_RESET        = 32'h0000_0000;
  localparam logic [31:0] PC_MASK         = 32'h03FF_FFFE;
  // Saved pc upper nibble zero at reset, rest left as zero here
  localparam logic [31:0] SAVED_PC_RESET  = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET    = 32'h0000_0020;
  localparam logic [31:0] SAVED_ST_RESET  = 32'h0000_0000;
  localparam logic [31:0] CAUSE_RESET     = 32'h0000_0000;
  localparam logic [31:0] TCB_RESET       = 32'h0000_0000;
  localparam logic [31:0] PC_STEP         = 32'h0000_0002;

  // Saving events
  typedef enum logic [2:0] {
    EV_NONE,
    EV_SW_EXCEPTION,
    EV_MASKABLE_INT,
    EV_NMI,
    EV_EXC_TRAP,
    EV_DEBUG_TRAP,
    EV_DEBUG_BREAK_STEP,
    EV_TABLE_CALL
  } save_event_t;

endpackage

// *** hw/pc_save_reg.sv ***
`timescale 1ns/1ps
module pc_save_reg (
  input  wire logic        clk,        // Clock
  input  wire logic        rst_n,      // Synchronised reset
  input  wire logic        save_en,    // Capture return address
  input  wire logic [31:0] save_val,   // Return address
  input  wire logic        load_en,    // Software load
  input  wire logic [31:0] load_val,   // Software value
  output logic      [31:0] value_r     // Stored value
);

  // Same layout as the pc: odd bit and high bits forced to zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value_r <= sysreg_pkg::SAVED_PC_RESET;
    end else if (save_en) begin
      value_r <= save_val & sysreg_pkg::PC_MASK;
    end else if (load_en) begin
      value_r <= load_val & sysreg_pkg::PC_MASK;
    end
  end

endmodule

// *** dv/cpu_system_register_file_assertions.sv ***
`timescale 1ns/1ps
module sysreg_checker (
  input wire logic        ref_clk,      // Clock
  input wire logic        reset_n,      // Reset
  input wire logic        load_sr,      // Load
  input wire logic        read_sr,      // Read
  input wire logic [4:0]  sr_number,    // Number
  input wire logic [31:0] sr_wdata,     // Load data
  input wire logic [2:0]  save_event,   // Event
  input wire logic        pc_inc,       // Step
  input wire logic        pc_load,      // Branch
  input wire logic [31:0] pc_target,    // Target
  input wire logic [31:0] sr_rdata_r,   // Read data
  input wire logic        sr_rvalid_r,  // Valid
  input wire logic        sr_rerror_r,  // Refused
  input wire logic [31:0] pc_r,         // Pc
  input wire logic [31:0] status_r,     // Status
  input wire logic        debug_mode_r  // Window
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  a_pc_bounds: assert property (pc_r[31:26] == 6'h00 && !pc_r[0]) else $error("pc bits");
  a_pc_step_wrap: assert property (pc_inc && !pc_load |=>
    pc_r == (($past(pc_r) + 32'h0000_0002) & sysreg_pkg::PC_MASK)) else $error("pc step");
  a_pc_branch: assert property (pc_load |=>
    pc_r == ($past(pc_target) & sysreg_pkg::PC_MASK)) else $error("pc branch");
  a_reset_pc: assert property ($rose(reset_n) |-> pc_r == 32'h0000_0000) else $error("pc reset");
  a_read_answer: assert property (read_sr |=> sr_rvalid_r) else $error("no read answer");
  a_valid_cause: assert property (sr_rvalid_r |-> $past(read_sr)) else $error("stray valid");
  a_status_load: assert property (load_sr && sr_number == sysreg_pkg::SR_PROGRAM_STATUS |=>
    status_r == $past(sr_wdata)) else $error("status load");
  a_debug_entry: assert property (save_event == 3'h5 |=> debug_mode_r) else $error("no window");
  a_debug_gate: assert property (read_sr && !debug_mode_r && save_event != 3'h5 &&
    sr_number[4:1] == 4'h9 |=> sr_rerror_r && sr_rdata_r == 32'h0000_0000) else $error("gate open");
  c_debug_read: cover property (read_sr && debug_mode_r && sr_number[4:1] == 4'h9);
  c_pc_wrap: cover property (pc_inc && pc_r == 32'h03FF_FFFE);
  c_refused: cover property (sr_rerror_r);
endmodule

bind cpu_system_register_file sysreg_checker u_sysreg_checker (.*);

// *** dv/pipeline_model.sv ***
`timescale 1ns/1ps
module pipeline_model (
  output logic        load_sr,      // Load
  output logic        read_sr,      // Read
  output logic [4:0]  sr_number,    // Number
  output logic [31:0] sr_wdata,     // Load data
  output logic [2:0]  save_event,   // Event
  output logic [31:0] next_pc,      // Next address
  output logic [31:0] cause_in,     // Cause
  output logic        cause_we,     // Cause strobe
  output logic        status_we,    // Status strobe
  output logic [31:0] status_in,    // Status
  output logic        pc_inc,       // Step
  output logic        pc_load,      // Branch
  output logic [31:0] pc_target,    // Target
  output logic        debug_return  // Debug return
);
  // One instruction per call; kind above 13 idles
  // Each pin is written once per call, so no strobe glitches
  task automatic step(input int k, input logic [31:0] v);
    int         kk;
    logic [6:0] st;
    logic [4:0] num;
    logic [2:0] ev;
    kk  = k < 0 ? int'($urandom_range(13)) : k;
    st  = 7'h00;
    ev  = 3'h0;
    num = 5'($urandom_range(10));
    if (num > 5'h05) num = num + 5'h0A;
    case (kk)
      0: st = 7'h40;
      1, 2: st = 7'h20;
      3: st = 7'h10;
      4: st = 7'h08;
      5: st = {4'h0, 2'($urandom_range(3, 1)), 1'b0};
      6: st = 7'h01;
      7, 8, 9, 10, 11, 12, 13: ev = 3'(kk - 6);
      default: ;
    endcase
    {load_sr, read_sr, pc_inc, pc_load, cause_we, status_we, debug_return} = st;
    save_event = ev;
    sr_number = num;
    sr_wdata = $urandom;
    next_pc = $urandom;
    cause_in = $urandom;
    status_in = $urandom;
    pc_target = k < 0 ? $urandom : v;
  endtask
endmodule

// *** dv/cpu_system_register_file_tb_top.sv ***
`timescale 1ns/1ps
module cpu_system_register_file_tb_top;
  logic        ref_clk, reset_n, load_sr, read_sr, pc_inc, pc_load, cause_we, status_we, debug_return;
  logic        sr_rvalid_r, sr_rerror_r, debug_mode_r;
  logic [4:0]  sr_number;
  logic [2:0]  save_event;
  logic [31:0] sr_wdata, next_pc, cause_in, status_in, pc_target, sr_rdata_r, pc_r, status_r, tc_base_r;
  logic [31:0] m [32];
  logic [31:0] pc_m, exp_rd;
  bit   [31:0] kn;
  bit          dbg, rd_p, err_p, kn_p;
  int          fails, n_tests;

  cpu_system_register_file u_cpu_system_register_file (.*);
  pipeline_model u_pipeline_model (.*);

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("compares %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic do_reset();
    reset_n = 1'b0;
    u_pipeline_model.step(15, 32'h0000_0000);
    m = '{default: sysreg_pkg::SAVED_PC_RESET};
    m[5] = sysreg_pkg::STATUS_RESET;
    pc_m = sysreg_pkg::PC_RESET;
    {dbg, rd_p, err_p} = 3'b000;
    kn = '1;
    repeat (3) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge ref_clk);
  endtask

  // Expected effect of the instruction now on the pins
  task automatic apply();
    int r;
    rd_p = read_sr;
    err_p = read_sr && !dbg && sr_number[4:1] == 4'h9;
    exp_rd = err_p ? 32'h0000_0000 : m[sr_number];
    kn_p = err_p || kn[sr_number];
    if (load_sr && sr_number != sysreg_pkg::SR_INTERRUPT_CAUSE) begin
      m[sr_number] = sr_wdata & (!sr_number[0] && sr_number[3:2] == 2'b00 ? sysreg_pkg::PC_MASK : '1);
      kn[sr_number] = 1'b1;
    end
    if (save_event != 3'h0) begin
      r = save_event == 3'h7 ? 16 : save_event == 3'h3 ? 2 : save_event > 3'h3 ? 18 : 0;
      m[r] = next_pc & sysreg_pkg::PC_MASK;
      m[r + 1] = m[5];
      kn[r + 1] = 1'b1;
      if (save_event == 3'h5) dbg = 1'b1;
    end
    if (debug_return) dbg = 1'b0;
    if (cause_we) m[4] = cause_in;
    if (status_we) m[5] = status_in;
    if (pc_load) pc_m = pc_target & sysreg_pkg::PC_MASK;
    else if (pc_inc) pc_m = (pc_m + 32'h0000_0002) & sysreg_pkg::PC_MASK;
  endtask

  task automatic cycle(input int k, input logic [31:0] v);
    @(negedge ref_clk);
    chk(pc_r, pc_m);
    chk(status_r, m[5]);
    chk(tc_base_r, m[20]);
    chk(32'(sr_rvalid_r), 32'(rd_p));
    chk(32'(sr_rerror_r), 32'(err_p));
    chk(32'(debug_mode_r), 32'(dbg));
    if (rd_p && kn_p) begin
      chk(sr_rdata_r, exp_rd);
    end
    u_pipeline_model.step(k, v);
    #1 apply();
  endtask
  ////////////////////////////////////////
  initial begin
    fails = 0;
    n_tests = 0;
    void'($urandom(19180));
    do_reset();
    chk(pc_r, 32'h0000_0000);
    cycle(4, 32'hFFFF_FFFF);
    cycle(3, 32'h0000_0000);
    repeat (1500) cycle(-1, 32'h0000_0000);
    cycle(4, 32'h0000_1236);
    do_reset();
    chk(pc_r, 32'h0000_0000);
    repeat (300) cycle(-1, 32'h0000_0000);
    cycle(15, 32'h0000_0000);
    close_out();
  end
endmodule
